// ==== verilog/band_regs_pkg.sv ====
// Constants and types shared by the banked gain and synthesiser register block
package band_regs_pkg;

    // Bus geometry: byte address, one register index per 32-bit word
    localparam int          ADDR_W          = 9;
    localparam int          IDX_W           = 7;
    localparam int          DATA_W          = 32;

    // Register indices; byte address is four times the index
    localparam logic [6:0]  IDX_OP_MODE     = 7'h01;
    localparam logic [6:0]  IDX_BANK_FIRST  = 7'h61;
    localparam logic [6:0]  IDX_BANK_LAST   = 7'h73;
    localparam logic [6:0]  IDX_AGC_REF     = 7'h61;
    localparam logic [6:0]  IDX_AGC_STEP1   = 7'h62;
    localparam logic [6:0]  IDX_AGC_STEP23  = 7'h63;
    localparam logic [6:0]  IDX_AGC_STEP45  = 7'h64;
    localparam logic [6:0]  IDX_SYNTH_BW    = 7'h70;

    // Operating-mode register
    localparam int          BAND_SELECT_POS = 3;
    localparam logic        BAND_SELECT_RST = 1'b1;
    localparam logic        BAND_HIGH       = 1'b0;
    localparam logic        BAND_LOW        = 1'b1;

    // Field positions
    localparam int          REF_MSB         = 5;
    localparam int          STEP1_MSB       = 4;
    localparam int          HI_NIB_LSB      = 4;
    localparam int          BW_LSB          = 6;

    // Lower-band reset values
    localparam logic [5:0]  LOW_REF_RST     = 6'h19;
    localparam logic [4:0]  LOW_STEP1_RST   = 5'h0C;
    localparam logic [3:0]  LOW_STEP2_RST   = 4'h4;
    localparam logic [3:0]  LOW_STEP3_RST   = 4'hB;
    localparam logic [3:0]  LOW_STEP4_RST   = 4'hC;
    localparam logic [3:0]  LOW_STEP5_RST   = 4'hC;

    // Upper-band reset values
    localparam logic [5:0]  HIGH_REF_RST    = 6'h1C;
    localparam logic [4:0]  HIGH_STEP1_RST  = 5'h0E;
    localparam logic [3:0]  HIGH_STEP2_RST  = 4'h5;
    localparam logic [3:0]  HIGH_STEP3_RST  = 4'hB;
    localparam logic [3:0]  HIGH_STEP4_RST  = 4'hC;
    localparam logic [3:0]  HIGH_STEP5_RST  = 4'hC;

    // Synthesiser register, both bands
    localparam logic [1:0]  BW_RST          = 2'h3;
    localparam logic [5:0]  PLL_RSV_RST     = 6'h10;
    localparam logic [8:0]  BW_KHZ_STEP     = 9'h04B;

    // Gain floor terms in dB / dBm
    localparam logic signed [8:0] NOISE_FLOOR_DBM = -9'sd174;
    localparam logic signed [8:0] FIXED_SNR_DB    = 9'sd8;

    // Avalon-MM response codes
    localparam logic [1:0]  RESP_OKAY       = 2'h0;
    localparam logic [1:0]  RESP_SLVERR     = 2'h2;

    // Bus handshake sequencer
    typedef enum logic {
        HS_IDLE = 1'b0,
        HS_ACK  = 1'b1
    } hs_state_t;

endpackage

// ==== verilog/avl_wait_seq.sv ====
// Avalon-MM one-wait-state handshake sequencer
`timescale 1ns/1ps
`default_nettype none

module avl_wait_seq
    import band_regs_pkg::*;
(
    input  wire logic core_clk,
    input  wire logic srst,
    input  wire logic req,
    output logic      start,
    output logic      commit,
    output logic      waitrequest
);

    hs_state_t state_r;
    hs_state_t state_nxt;

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            HS_IDLE: begin
                if (req) begin
                    state_nxt = HS_ACK;
                end
            end
            HS_ACK: begin
                state_nxt = HS_IDLE;
            end
            default: begin
                state_nxt = HS_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            state_r <= HS_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Wait request is low exactly in the acknowledge cycle
    assign waitrequest = (state_r != HS_ACK);
    assign start       = (state_r == HS_IDLE) && req;
    assign commit      = (state_r == HS_ACK);

endmodule

`default_nettype wire

// ==== verilog/band_bank.sv ====
// One band copy of the gain threshold and synthesiser bandwidth registers
`timescale 1ns/1ps
`default_nettype none

module band_bank
    import band_regs_pkg::*;
#(
    parameter logic [5:0] REF_RST   = 6'h19,
    parameter logic [4:0] STEP1_RST = 5'h0C,
    parameter logic [3:0] STEP2_RST = 4'h4,
    parameter logic [3:0] STEP3_RST = 4'hB,
    parameter logic [3:0] STEP4_RST = 4'hC,
    parameter logic [3:0] STEP5_RST = 4'hC
) (
    input  wire logic       core_clk,
    input  wire logic       srst,
    input  wire logic       wr_en,
    input  wire logic [6:0] wr_index,
    input  wire logic [7:0] wr_data,
    output logic      [5:0] gain_floor_offset,
    output logic      [4:0] gain_threshold_one,
    output logic      [3:0] gain_threshold_two,
    output logic      [3:0] gain_threshold_three,
    output logic      [3:0] gain_threshold_four,
    output logic      [3:0] gain_threshold_five,
    output logic      [1:0] synth_loop_bandwidth,
    output logic      [5:0] synth_reserved
);

    // Only the implemented bits are stored; the rest read as zero
    always_ff @(posedge core_clk) begin
        if (srst) begin
            gain_floor_offset  <= REF_RST;
            gain_threshold_one <= STEP1_RST;
        end else if (wr_en && wr_index == IDX_AGC_REF) begin
            gain_floor_offset  <= wr_data[REF_MSB:0];
        end else if (wr_en && wr_index == IDX_AGC_STEP1) begin
            gain_threshold_one <= wr_data[STEP1_MSB:0];
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            gain_threshold_two   <= STEP2_RST;
            gain_threshold_three <= STEP3_RST;
            gain_threshold_four  <= STEP4_RST;
            gain_threshold_five  <= STEP5_RST;
        end else if (wr_en && wr_index == IDX_AGC_STEP23) begin
            gain_threshold_two   <= wr_data[7:HI_NIB_LSB];
            gain_threshold_three <= wr_data[HI_NIB_LSB-1:0];
        end else if (wr_en && wr_index == IDX_AGC_STEP45) begin
            gain_threshold_four  <= wr_data[7:HI_NIB_LSB];
            gain_threshold_five  <= wr_data[HI_NIB_LSB-1:0];
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            synth_loop_bandwidth <= BW_RST;
            synth_reserved       <= PLL_RSV_RST;
        end else if (wr_en && wr_index == IDX_SYNTH_BW) begin
            synth_loop_bandwidth <= wr_data[7:BW_LSB];
            synth_reserved       <= wr_data[BW_LSB-1:0];
        end
    end

endmodule

`default_nettype wire

// ==== verilog/band_banked_agc_pll_regs.sv ====
// Banked gain control and synthesiser bandwidth registers on an Avalon-MM slave
//
// Notes on behaviour
// - 0x61..0x73 has separate lower and upper copies
// - band bit set selects lower, clear upper
// - switching band never alters either copy
// - band bit resets to 1, lower visible
// - synth bandwidth bits 7-6, reset 0x03
// - floor offset adds to noise plus SNR
// - threshold one is bits 4-0 at 0x62
// - thresholds two..five are nibbles at 0x63/0x64
// - lower-band copy reset values
// - upper-band copy reset values
// - band bit is bit 3 at 0x01
`timescale 1ns/1ps
`default_nettype none

module band_banked_agc_pll_regs
    import band_regs_pkg::*;
(
    input  wire logic                core_clk,
    input  wire logic                srst,
    // Avalon-MM slave
    input  wire logic [ADDR_W-1:0]   address,
    input  wire logic                read,
    input  wire logic                write,
    input  wire logic [DATA_W-1:0]   writedata,
    input  wire logic [3:0]          byteenable,
    output logic      [DATA_W-1:0]   readdata,
    output logic      [1:0]          response,
    output logic                     waitrequest,
    // Settings of the band in use
    output logic                     band_select_bit,
    output logic      [5:0]          gain_floor_offset,
    output logic      [4:0]          gain_threshold_one,
    output logic      [3:0]          gain_threshold_two,
    output logic      [3:0]          gain_threshold_three,
    output logic      [3:0]          gain_threshold_four,
    output logic      [3:0]          gain_threshold_five,
    output logic      [1:0]          synth_loop_bandwidth,
    output logic      [8:0]          synth_loop_khz,
    output logic signed [8:0]        gain_base_dbm
);

    // Register index within the word-aligned map
    function automatic logic in_bank_range(input logic [IDX_W-1:0] idx);
        in_bank_range = (idx >= IDX_BANK_FIRST) && (idx <= IDX_BANK_LAST);
    endfunction

    function automatic logic idx_mapped(input logic [IDX_W-1:0] idx);
        idx_mapped = (idx == IDX_OP_MODE) || in_bank_range(idx);
    endfunction

    // Bandwidth code to kHz: 75, 150, 225, 300
    function automatic logic [8:0] bw_to_khz(input logic [1:0] code);
        logic [8:0] mult;
        mult      = {7'h00, code} + 9'h001;
        bw_to_khz = 9'(mult * BW_KHZ_STEP);
    endfunction

    logic [IDX_W-1:0] idx;
    logic             hs_start;
    logic             hs_commit;
    logic             band_select_r;
    logic             wr_fire;
    logic [7:0]       wr_byte;

    assign idx     = address[ADDR_W-1:2];
    assign wr_byte = writedata[7:0];
    // Write lands at the edge that the master sees waitrequest low
    assign wr_fire = hs_commit && write && byteenable[0];

    avl_wait_seq u_seq (
        .core_clk    (core_clk),
        .srst        (srst),
        .req         (read || write),
        .start       (hs_start),
        .commit      (hs_commit),
        .waitrequest ()
    );

    always_ff @(posedge core_clk) begin
        if (srst) begin
            waitrequest <= 1'b1;
        end else begin
            waitrequest <= !hs_start;
        end
    end

    // Band-select bit in the operating-mode register
    always_ff @(posedge core_clk) begin
        if (srst) begin
            band_select_r <= BAND_SELECT_RST;
        end else if (wr_fire && idx == IDX_OP_MODE) begin
            band_select_r <= wr_byte[BAND_SELECT_POS];
        end
    end

    // Bank outputs, indexed by band value: 1 lower, 0 upper
    logic [5:0] ref_q   [2];
    logic [4:0] step1_q [2];
    logic [3:0] step2_q [2];
    logic [3:0] step3_q [2];
    logic [3:0] step4_q [2];
    logic [3:0] step5_q [2];
    logic [1:0] bw_q    [2];
    logic [5:0] rsv_q   [2];

    // Only the bank named by the band bit sees writes; the other keeps its values
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_bank
            logic bank_wr;
            assign bank_wr = wr_fire && in_bank_range(idx)
                           && (band_select_r == 1'(g));
            band_bank #(
                .REF_RST   ((g == 1) ? LOW_REF_RST   : HIGH_REF_RST),
                .STEP1_RST ((g == 1) ? LOW_STEP1_RST : HIGH_STEP1_RST),
                .STEP2_RST ((g == 1) ? LOW_STEP2_RST : HIGH_STEP2_RST),
                .STEP3_RST ((g == 1) ? LOW_STEP3_RST : HIGH_STEP3_RST),
                .STEP4_RST ((g == 1) ? LOW_STEP4_RST : HIGH_STEP4_RST),
                .STEP5_RST ((g == 1) ? LOW_STEP5_RST : HIGH_STEP5_RST)
            ) u_bank (
                .core_clk             (core_clk),
                .srst                 (srst),
                .wr_en                (bank_wr),
                .wr_index             (idx),
                .wr_data              (wr_byte),
                .gain_floor_offset    (ref_q[g]),
                .gain_threshold_one   (step1_q[g]),
                .gain_threshold_two   (step2_q[g]),
                .gain_threshold_three (step3_q[g]),
                .gain_threshold_four  (step4_q[g]),
                .gain_threshold_five  (step5_q[g]),
                .synth_loop_bandwidth (bw_q[g]),
                .synth_reserved       (rsv_q[g])
            );
        end
    endgenerate

    // Read mux over the visible bank
    logic [7:0] rd_byte;
    logic       b;

    assign b = band_select_r;

    always_comb begin
        rd_byte = 8'h00;
        case (idx)
            IDX_OP_MODE: begin
                rd_byte = 8'(band_select_r) << BAND_SELECT_POS;
            end
            IDX_AGC_REF: begin
                rd_byte = {2'h0, ref_q[b]};
            end
            IDX_AGC_STEP1: begin
                rd_byte = {3'h0, step1_q[b]};
            end
            IDX_AGC_STEP23: begin
                rd_byte = {step2_q[b], step3_q[b]};
            end
            IDX_AGC_STEP45: begin
                rd_byte = {step4_q[b], step5_q[b]};
            end
            IDX_SYNTH_BW: begin
                rd_byte = {bw_q[b], rsv_q[b]};
            end
            default: begin
                rd_byte = 8'h00;
            end
        endcase
    end

    // Read data and response are captured as the request is taken
    always_ff @(posedge core_clk) begin
        if (srst) begin
            readdata <= '0;
        end else if (hs_start) begin
            readdata <= read ? {24'h000000, rd_byte} : '0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            response <= RESP_OKAY;
        end else if (hs_start) begin
            response <= idx_mapped(idx) ? RESP_OKAY : RESP_SLVERR;
        end
    end

    // Live settings of the band in use, one cycle behind the registers
    always_ff @(posedge core_clk) begin
        if (srst) begin
            band_select_bit      <= BAND_SELECT_RST;
            gain_floor_offset    <= LOW_REF_RST;
            gain_threshold_one   <= LOW_STEP1_RST;
            gain_threshold_two   <= LOW_STEP2_RST;
            gain_threshold_three <= LOW_STEP3_RST;
            gain_threshold_four  <= LOW_STEP4_RST;
            gain_threshold_five  <= LOW_STEP5_RST;
            synth_loop_bandwidth <= BW_RST;
        end else begin
            band_select_bit      <= band_select_r;
            gain_floor_offset    <= ref_q[b];
            gain_threshold_one   <= step1_q[b];
            gain_threshold_two   <= step2_q[b];
            gain_threshold_three <= step3_q[b];
            gain_threshold_four  <= step4_q[b];
            gain_threshold_five  <= step5_q[b];
            synth_loop_bandwidth <= bw_q[b];
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            synth_loop_khz <= bw_to_khz(BW_RST);
        end else begin
            synth_loop_khz <= bw_to_khz(bw_q[b]);
        end
    end

    // Floor without the bandwidth term: -174 + 8 + offset
    always_ff @(posedge core_clk) begin
        if (srst) begin
            gain_base_dbm <= NOISE_FLOOR_DBM + FIXED_SNR_DB + $signed({3'h0, LOW_REF_RST});
        end else begin
            gain_base_dbm <= NOISE_FLOOR_DBM + FIXED_SNR_DB
                           + $signed({3'h0, ref_q[b]});
        end
    end

endmodule

`default_nettype wire

// ==== tb/band_regs_asserts.sv ====
// Port-level assertions for the banked gain and synthesiser registers
`timescale 1ns/1ps
`default_nettype none

module band_regs_asserts
    import band_regs_pkg::*;
(
    input wire logic              core_clk,
    input wire logic              srst,
    input wire logic [8:0]        address,
    input wire logic              read,
    input wire logic              write,
    input wire logic [31:0]       readdata,
    input wire logic [1:0]        response,
    input wire logic              waitrequest,
    input wire logic              band_select_bit,
    input wire logic [5:0]        gain_floor_offset,
    input wire logic [1:0]        synth_loop_bandwidth,
    input wire logic [8:0]        synth_loop_khz,
    input wire logic signed [8:0] gain_base_dbm
);
    logic [6:0] idx;
    logic       mapped;
    assign idx    = address[8:2];
    assign mapped = (idx == IDX_OP_MODE) || (idx >= IDX_BANK_FIRST && idx <= IDX_BANK_LAST);

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);

    band_reset_a: assert property ($fell(srst) |-> band_select_bit == BAND_SELECT_RST)
        else $error("band bit wrong after reset");
    field_reset_a: assert property ($fell(srst) |-> gain_floor_offset == LOW_REF_RST
        && synth_loop_bandwidth == BW_RST) else $error("fields wrong after reset");
    khz_map_a: assert property (synth_loop_bandwidth == $past(synth_loop_bandwidth)
        && synth_loop_bandwidth == $past(synth_loop_bandwidth, 2)
        |-> synth_loop_khz == BW_KHZ_STEP * ({7'h00, synth_loop_bandwidth} + 9'h001))
        else $error("loop bandwidth in kHz wrong");
    gain_base_a: assert property (gain_floor_offset == $past(gain_floor_offset)
        && gain_floor_offset == $past(gain_floor_offset, 2)
        |-> gain_base_dbm == NOISE_FLOOR_DBM + FIXED_SNR_DB + $signed({3'b000, gain_floor_offset}))
        else $error("gain base level wrong");
    band_hold_a: assert property ($changed(band_select_bit) && !$past(srst) && !$past(srst, 2)
        |-> $past(write) || $past(write, 2) || $past(write, 3))
        else $error("band bit moved without a write");
    mode_read_a: assert property (read && !waitrequest && idx == IDX_OP_MODE
        |-> readdata == {28'h0, band_select_bit, 3'h0}) else $error("mode register read wrong");
    resp_map_a: assert property ((read || write) && waitrequest
        |-> ##[1:2] (!waitrequest && response == (mapped ? RESP_OKAY : RESP_SLVERR)))
        else $error("response missing or wrong");
    wait_one_a: assert property (!waitrequest |=> waitrequest)
        else $error("waitrequest low too long");
    data_upper_a: assert property (!waitrequest |-> readdata[31:8] == 24'h0)
        else $error("upper read bytes not zero");
    ref_mask_a: assert property (read && !waitrequest && idx == IDX_AGC_REF
        |-> readdata[7:6] == 2'h0) else $error("reference unused bits not zero");
    step_mask_a: assert property (read && !waitrequest && idx == IDX_AGC_STEP1
        |-> readdata[7:5] == 3'h0) else $error("step one unused bits not zero");
endmodule

`default_nettype wire

// ==== tb/testbench.sv ====
// Directed register-bus tests for the banked gain and synthesiser registers
`timescale 1ns/1ps
`default_nettype none

module testbench
    import band_regs_pkg::*;
;
    logic              core_clk = 1'b0;
    logic              srst = 1'b1;
    logic              read = 1'b0;
    logic              write = 1'b0;
    logic [8:0]        address = 9'h000;
    logic [31:0]       writedata = 32'h0;
    logic [3:0]        byteenable = 4'h0;
    logic [31:0]       readdata, last_rd;
    logic [1:0]        response, last_rs;
    logic              waitrequest, band_select_bit;
    logic [5:0]        gain_floor_offset;
    logic [4:0]        gain_threshold_one;
    logic [3:0]        gain_threshold_two, gain_threshold_three;
    logic [3:0]        gain_threshold_four, gain_threshold_five;
    logic [1:0]        synth_loop_bandwidth;
    logic [8:0]        synth_loop_khz;
    logic signed [8:0] gain_base_dbm;
    int                errors = 0;
    int                checked = 0;
    int                cycles = 0;
    logic [8:0]        bank_a [5] = '{9'h184, 9'h188, 9'h18C, 9'h190, 9'h1C0};
    logic [7:0]        low_v [5]  = '{8'h19, 8'h0C, 8'h4B, 8'hCC, 8'hD0};
    logic [7:0]        high_v [5] = '{8'h1C, 8'h0E, 8'h5B, 8'hCC, 8'hD0};
    logic [7:0]        new_v [5]  = '{8'h2A, 8'h15, 8'hA7, 8'h3D, 8'h50};

    band_banked_agc_pll_regs DUT (
        .core_clk(core_clk), .srst(srst), .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
        .response(response), .waitrequest(waitrequest), .band_select_bit(band_select_bit),
        .gain_floor_offset(gain_floor_offset), .gain_threshold_one(gain_threshold_one),
        .gain_threshold_two(gain_threshold_two), .gain_threshold_three(gain_threshold_three),
        .gain_threshold_four(gain_threshold_four), .gain_threshold_five(gain_threshold_five),
        .synth_loop_bandwidth(synth_loop_bandwidth), .synth_loop_khz(synth_loop_khz),
        .gain_base_dbm(gain_base_dbm)
    );

    initial begin
        forever #12.5 core_clk = ~core_clk;
    end

    task automatic give_verdict();
        if (errors == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            errors++;
            give_verdict();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One bus transfer, held until waitrequest is sampled low
    task automatic xfer(input logic w, input logic [8:0] a, input logic [7:0] d,
                        input logic [3:0] be);
        int n;
        n = 0;
        @(posedge core_clk);
        read <= ~w;
        write <= w;
        address <= a;
        writedata <= {24'h0, d};
        byteenable <= be;
        do begin
            @(posedge core_clk);
            n++;
        end while (waitrequest !== 1'b0 && n < 20);
        if (n >= 20) begin
            errors++;
        end
        last_rd = readdata;
        last_rs = response;
        read <= 1'b0;
        write <= 1'b0;
    endtask

    task automatic rc(input logic [8:0] a, input logic [7:0] exp);
        xfer(1'b0, a, 8'h00, 4'hF);
        chk(last_rd, {24'h0, exp});
    endtask

    task automatic wr(input logic [8:0] a, input logic [7:0] d);
        xfer(1'b1, a, d, 4'hF);
    endtask

    initial begin
        repeat (5) @(posedge core_clk);
        srst <= 1'b0;
        rc(9'h004, 8'h08);
        for (int i = 0; i < 5; i++) rc(bank_a[i], low_v[i]);
        wr(9'h004, 8'hFF);
        rc(9'h004, 8'h08);
        wr(9'h004, 8'h00);
        rc(9'h004, 8'h00);
        for (int i = 0; i < 5; i++) rc(bank_a[i], high_v[i]);
        for (int i = 0; i < 5; i++) wr(bank_a[i], new_v[i]);
        for (int i = 0; i < 5; i++) rc(bank_a[i], new_v[i]);
        repeat (2) @(posedge core_clk);
        chk({27'h0, gain_threshold_one}, 32'h15);
        chk({16'h0, gain_threshold_two, gain_threshold_three, gain_threshold_four,
             gain_threshold_five}, 32'hA73D);
        chk(32'(gain_base_dbm), 32'(-124));
        wr(9'h004, 8'h08);
        for (int i = 0; i < 5; i++) rc(bank_a[i], low_v[i]);
        wr(9'h184, 8'hFF);
        rc(9'h184, 8'h3F);
        wr(9'h188, 8'hFF);
        rc(9'h188, 8'h1F);
        for (int c = 0; c < 4; c++) begin
            wr(9'h1C0, {c[1:0], 6'h10});
            repeat (2) @(posedge core_clk);
            chk({23'h0, synth_loop_khz}, 32'(75 * (c + 1)));
        end
        wr(9'h004, 8'h00);
        for (int i = 0; i < 5; i++) rc(bank_a[i], new_v[i]);
        xfer(1'b1, 9'h184, 8'h01, 4'h0);
        rc(9'h184, 8'h2A);
        rc(9'h194, 8'h00);
        chk({30'h0, last_rs}, {30'h0, RESP_OKAY});
        rc(9'h000, 8'h00);
        chk({30'h0, last_rs}, {30'h0, RESP_SLVERR});
        srst <= 1'b1;
        repeat (2) @(posedge core_clk);
        srst <= 1'b0;
        rc(9'h004, 8'h08);
        for (int i = 0; i < 5; i++) rc(bank_a[i], low_v[i]);
        give_verdict();
    end
endmodule

bind band_banked_agc_pll_regs band_regs_asserts chk_i (
    .core_clk(core_clk), .srst(srst), .address(address), .read(read), .write(write),
    .readdata(readdata), .response(response), .waitrequest(waitrequest),
    .band_select_bit(band_select_bit), .gain_floor_offset(gain_floor_offset),
    .synth_loop_bandwidth(synth_loop_bandwidth), .synth_loop_khz(synth_loop_khz),
    .gain_base_dbm(gain_base_dbm)
);

`default_nettype wire
